// file: core/smc_pkg.sv
// Types shared by the system management controller core.
// Assumes smc_regs.svh supplies the numeric constants.
package smc_pkg;
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_UP = 3'b010,
    SEQ_DOWN = 3'b100
  } smc_seq_e;
  typedef logic [3:0] smc_mst_t;
  typedef logic [3:0] smc_int_t;
  typedef logic [3:0][7:0] smc_vout_t;
  typedef logic [3:0][4:0] smc_dly_t;
endpackage

// file: core/smc_regs.svh
// Register offsets, field positions, reset values and timing constants
// of the system management controller; included by the core modules.
`ifndef SMC_REGS_SVH
`define SMC_REGS_SVH

// Register offsets (7-bit serial address space)
`define SMC_A_INT_SRC 7'h01
`define SMC_A_INT 7'h02
`define SMC_A_MASK 7'h03
`define SMC_A_STATUS 7'h04
`define SMC_A_RESET 7'h05
`define SMC_A_MEN 7'h06
`define SMC_A_CFG 7'h07
`define SMC_A_VOUT0 7'h08
`define SMC_A_STUP0 7'h0C
`define SMC_A_SHDN0 7'h10

// Field positions
`define SMC_RST_BIT 0
`define SMC_SRC_INT_BIT 0
`define SMC_CFG_UVLO_LSB 0
`define SMC_CFG_WDT_LSB 4
`define SMC_INT_WARN_LO 0
`define SMC_INT_WARN_HI 1
`define SMC_INT_THERMAL_SHUTDOWN_LIMIT 2
`define SMC_INT_WDT 3

// Reset values
`define SMC_MASK_RST 4'hF
`define SMC_VOUT_RST 8'h8C
`define SMC_UVLO_RST 3'h3
`define SMC_WDT_RST 3'h2
`define SMC_STUP_RST 5'h01
`define SMC_SHDN_RST 5'h00
`define SMC_RD_NONE 8'h00
`define SMC_SPI_NO_DATA 8'hFF

// Timing
`define SMC_CLK_PERIOD_NS 10
`define SMC_BIAS_SETTLE_NS 50000
`define SMC_MS_NS 1000000
`define SMC_SEQ_END_MS 6'h3E

// Link frame bit counts
`define SMC_SPI_CMD_END 5'h07
`define SMC_SPI_WR_END 5'h0F
`define SMC_SPI_RD_FIRST 5'h10
`define SMC_SPI_RD_LAST 5'h17
`define SMC_SPI_CNT_MAX 5'h1F

`endif

// file: core/smc_spi_link.sv
// Serial register link on the host's clock: mode 0, MSB first.
// Assumes the host stops the clock outside frames; chip select resets the frame.
`timescale 1ns/1ps
`include "smc_regs.svh"
module smc_spi_link (
  input wire logic arst_n_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_o,
  output logic req_tgl_o,
  output logic req_wr_o,
  output logic [6:0] req_addr_o,
  output logic [7:0] req_wdata_o,
  input wire logic ack_tgl_i,
  input wire logic [7:0] rdata_i
);
  logic [4:0] cnt_r;
  logic [7:0] sh_r;
  logic [7:0] out_r;
  logic [1:0] ack_s_r;

  // Bit counter, cleared between frames
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      cnt_r <= 5'h00;
      sh_r <= 8'h00;
    end else begin
      sh_r <= {sh_r[6:0], mosi_i};
      if (cnt_r != `SMC_SPI_CNT_MAX) begin
        cnt_r <= cnt_r + 5'h01;
      end
    end
  end

  // Request fields held until the next command byte; a write toggles only after its data byte
  always_ff @(posedge sclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      req_tgl_o <= 1'b0;
      req_wr_o <= 1'b0;
      req_addr_o <= 7'h00;
      req_wdata_o <= 8'h00;
    end else if (!cs_n_i) begin
      if (cnt_r == `SMC_SPI_CMD_END) begin
        req_wr_o <= ~sh_r[6];
        req_addr_o <= {sh_r[5:0], mosi_i};
        if (sh_r[6]) begin
          req_tgl_o <= ~req_tgl_o;
        end
      end else if (cnt_r == `SMC_SPI_WR_END && req_wr_o) begin
        req_wdata_o <= {sh_r[6:0], mosi_i};
        req_tgl_o <= ~req_tgl_o;
      end
    end
  end

  // Acknowledge toggle synchroniser
  always_ff @(posedge sclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_s_r <= 2'b00;
    end else begin
      ack_s_r <= {ack_s_r[0], ack_tgl_i};
    end
  end

  // Read data: loaded once the answer has crossed, then shifted
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      out_r <= `SMC_SPI_NO_DATA;
    end else if (cnt_r == `SMC_SPI_WR_END) begin
      out_r <= (ack_s_r[1] == req_tgl_o) ? rdata_i : `SMC_SPI_NO_DATA;
    end else if (cnt_r >= `SMC_SPI_RD_FIRST) begin
      out_r <= {out_r[6:0], 1'b0};
    end
  end

  // Drive data on falling edges during the read data byte only
  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      miso_o <= 1'b0;
      miso_oe_o <= 1'b0;
    end else if (!req_wr_o && cnt_r >= `SMC_SPI_RD_FIRST && cnt_r <= `SMC_SPI_RD_LAST) begin
      miso_o <= out_r[7];
      miso_oe_o <= 1'b1;
    end else begin
      miso_o <= 1'b0;
      miso_oe_o <= 1'b0;
    end
  end
endmodule // smc_spi_link

// file: core/smc_top.sv
// System management controller: faults, reset classes, standby and bias,
// master enables, sequencer, interrupts and the register file.
// Assumes supply and thermal comparators and pins arrive asynchronously.
//
// Functional notes
// - Supply below falling level shuts down; resume only once above rising level.
// - Falling level is a 3-bit field; software keeps it below rising level.
// - IO supply below its good threshold forces shutdown until it recovers.
// - Over-temperature soft-stops outputs, resets off-class registers, link stays usable.
// - Two thermal warning levels each raise an interrupt.
// - Power-on enables reference and loads defaults; shutdown until chip enable.
// - Supply below power-on level resets all system-class registers.
// - Every power-off or shutdown event resets all off-class registers.
// - Writing one to soft reset bit resets off-class registers, bit self-clears.
// - Watchdog input low past selected debounce restores default output voltages.
// - Chip enable high gives standby; masters wait fifty microseconds of bias settling.
// - Chip enable low shuts everything off and resets off-class registers.
// - Master is on when register enable, global enable or input enable is set.
// - Enable pin or global enable starts sequences; delays 0 to 62 ms, 32 steps.
// - Master one starts at once; others use startup delays; shutdown delays for all.
// - Masters already driven by own sources are untouched by a global sequence.
// - Request line goes low on any unmasked interrupt; source register guides reads.
// - Interrupt bits set on condition edges or on unmasking, not repeatedly while active.
// - Interrupt bits clear on read; a new event during a read keeps request low.
// - Masked events neither set bits nor request; unmasking captures active condition.
// - Mask bits default to masked and return there on every power-off event.
`timescale 1ns/1ps
`include "smc_regs.svh"
module smc_top
  import smc_pkg::*;
#(
  parameter int BIAS_CYC = (`SMC_BIAS_SETTLE_NS + `SMC_CLK_PERIOD_NS - 1) / `SMC_CLK_PERIOD_NS,
  parameter int MS_CYC = `SMC_MS_NS / `SMC_CLK_PERIOD_NS
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic clk_en_i,
  input wire logic spi_sclk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_o,
  input wire logic por_ok_i,
  input wire logic supply_fall_trip_i,
  input wire logic supply_rise_ok_i,
  input wire logic io_supply_ok_i,
  input wire logic therm_shdn_i,
  input wire logic therm_cool_i,
  input wire logic therm_warn_lo_i,
  input wire logic therm_warn_hi_i,
  input wire logic chip_enable_i,
  input wire logic en_pin_i,
  input wire logic global_enable_function_i,
  input wire logic [3:0] master_input_enable_i,
  input wire logic watchdog_reset_n_input_i,
  output logic ref_enable_o,
  output logic otp_load_o,
  output logic standby_o,
  output logic bias_ready_o,
  output logic soft_stop_o,
  output logic [3:0] master_on_o,
  output smc_vout_t master_voltage_setting_o,
  output logic [2:0] supply_low_fall_level_o,
  output logic irq_n_o
);
  function automatic logic in_grp(input logic [6:0] a, input logic [6:0] base);
    return a[6:2] == base[6:2];
  endfunction

  function automatic logic reached(input logic [5:0] el_ms, input logic [4:0] dly);
    return el_ms >= {dly, 1'b0};
  endfunction

  logic [1:0] rst_pipe_r;
  logic rst_n;
  logic [15:0] pin_s1_r;
  logic [15:0] pin_s2_r;
  logic por_s, fall_s, rise_s, io_s, thermal_shutdown_limit_s, cool_s, wlo_s, whi_s;
  logic ce_s, enp_s, gef_s, wd_n_s;
  smc_mst_t min_s;
  logic uvlo_r, thermal_shutdown_limit_r, por_d_r, soft_reset_bit_r;
  logic shut, off_rst, sys_rst;
  logic [12:0] bias_cnt_r;
  logic [16:0] ms_cnt_r;
  logic ms_tick;
  logic [3:0] wdt_cnt_r;
  logic wdt_fired_r, wdt_evt;
  smc_seq_e seq_r;
  logic trig_d_r;
  logic [5:0] el_r;
  smc_mst_t excl_r, glb_on_r, men_r;
  smc_vout_t vout_r;
  smc_dly_t stup_r, shdn_r;
  logic [2:0] wdt_sel_r;
  smc_int_t int_r, mask_r, cond_d_r, mask_d_r, cond, evt, pend;
  logic [2:0] req_s_r;
  logic req_evt, req_tgl, req_wr, ack_tgl_r, rd_int;
  logic [6:0] req_addr;
  logic [7:0] req_wdata, rdata_r, rd_mux;

  // Reset release through two flops
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_pipe_r <= 2'b00;
    end else if (clk_en_i) begin
      rst_pipe_r <= {rst_pipe_r[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe_r[1];

  // Pin and comparator synchronisers
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r <= 16'h0000;
      pin_s2_r <= 16'h0000;
    end else if (clk_en_i) begin
      pin_s1_r <= {por_ok_i, supply_fall_trip_i, supply_rise_ok_i, io_supply_ok_i,
                   therm_shdn_i, therm_cool_i, therm_warn_lo_i, therm_warn_hi_i,
                   chip_enable_i, en_pin_i, global_enable_function_i,
                   master_input_enable_i, watchdog_reset_n_input_i};
      pin_s2_r <= pin_s1_r;
    end
  end
  assign {por_s, fall_s, rise_s, io_s, thermal_shutdown_limit_s, cool_s, wlo_s, whi_s,
          ce_s, enp_s, gef_s, min_s, wd_n_s} = pin_s2_r;

  assign sys_rst = ~por_s;
  assign shut = ~ce_s | uvlo_r | ~io_s | thermal_shutdown_limit_r | ~por_s;
  assign off_rst = shut | soft_reset_bit_r;

  // Undervoltage lockout with hysteresis, asserted from reset
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      uvlo_r <= 1'b1;
    end else if (clk_en_i) begin
      if (fall_s || !por_s) begin
        uvlo_r <= 1'b1;
      end else if (rise_s) begin
        uvlo_r <= 1'b0;
      end
    end
  end

  // Thermal shutdown held until the die cools by the hysteresis
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      thermal_shutdown_limit_r <= 1'b0;
    end else if (clk_en_i) begin
      if (thermal_shutdown_limit_s) begin
        thermal_shutdown_limit_r <= 1'b1;
      end else if (cool_s) begin
        thermal_shutdown_limit_r <= 1'b0;
      end
    end
  end

  // Reference enable and default load on power-on
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      por_d_r <= 1'b0;
      ref_enable_o <= 1'b0;
      otp_load_o <= 1'b0;
      soft_stop_o <= 1'b0;
      standby_o <= 1'b0;
    end else if (clk_en_i) begin
      por_d_r <= por_s;
      ref_enable_o <= por_s;
      otp_load_o <= por_s & ~por_d_r;
      soft_stop_o <= thermal_shutdown_limit_r;
      standby_o <= ~shut;
    end
  end

  // Bias settling timer
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bias_cnt_r <= 13'h0000;
      bias_ready_o <= 1'b0;
    end else if (clk_en_i) begin
      if (shut) begin
        bias_cnt_r <= 13'h0000;
        bias_ready_o <= 1'b0;
      end else if (bias_cnt_r == 13'(BIAS_CYC - 1)) begin
        bias_ready_o <= 1'b1;
      end else begin
        bias_cnt_r <= bias_cnt_r + 13'h0001;
      end
    end
  end

  // Millisecond tick
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_r <= 17'h00000;
    end else if (clk_en_i) begin
      ms_cnt_r <= ms_tick ? 17'h00000 : ms_cnt_r + 17'h00001;
    end
  end
  assign ms_tick = ms_cnt_r == 17'(MS_CYC - 1);

  // Watchdog input debounce, one event per low period
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wdt_cnt_r <= 4'h0;
      wdt_fired_r <= 1'b0;
    end else if (clk_en_i) begin
      if (wd_n_s) begin
        wdt_cnt_r <= 4'h0;
        wdt_fired_r <= 1'b0;
      end else if (!wdt_fired_r && wdt_cnt_r > {1'b0, wdt_sel_r}) begin
        wdt_fired_r <= 1'b1;
      end else if (ms_tick && !wdt_fired_r) begin
        wdt_cnt_r <= wdt_cnt_r + 4'h1;
      end
    end
  end
  assign wdt_evt = ~wdt_fired_r & ~wd_n_s & (wdt_cnt_r > {1'b0, wdt_sel_r});

  // Global startup and shutdown sequencer
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      seq_r <= SEQ_IDLE;
      trig_d_r <= 1'b0;
      el_r <= 6'h00;
      excl_r <= 4'h0;
      glb_on_r <= 4'h0;
    end else if (clk_en_i) begin
      trig_d_r <= enp_s | gef_s;
      if (off_rst) begin
        seq_r <= SEQ_IDLE;
        glb_on_r <= 4'h0;
      end else if ((enp_s | gef_s) != trig_d_r) begin
        seq_r <= trig_d_r ? SEQ_DOWN : SEQ_UP;
        el_r <= 6'h00;
        excl_r <= men_r | min_s;
      end else begin
        unique case (seq_r)
          SEQ_IDLE: begin
          end
          SEQ_UP: begin
            for (int k = 0; k < 4; k++) begin
              if (!excl_r[k] && (k == 0 || reached(el_r, stup_r[k]))) begin
                glb_on_r[k] <= 1'b1;
              end
            end
          end
          SEQ_DOWN: begin
            for (int k = 0; k < 4; k++) begin
              if (!excl_r[k] && reached(el_r, shdn_r[k])) begin
                glb_on_r[k] <= 1'b0;
              end
            end
          end
        endcase
        if (seq_r != SEQ_IDLE && ms_tick) begin
          if (el_r == `SMC_SEQ_END_MS) begin
            seq_r <= SEQ_IDLE;
          end else begin
            el_r <= el_r + 6'h01;
          end
        end
      end
    end
  end

  // Master enables, gated by shutdown and bias
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      master_on_o <= 4'h0;
    end else if (clk_en_i) begin
      if (shut || !bias_ready_o) begin
        master_on_o <= 4'h0;
      end else begin
        master_on_o <= men_r | glb_on_r | min_s;
      end
    end
  end

  // Link request crossing; first flop feeds only the second
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      req_s_r <= 3'b000;
    end else if (clk_en_i) begin
      req_s_r <= {req_s_r[1:0], req_tgl};
    end
  end
  assign req_evt = req_s_r[2] ^ req_s_r[1];
  assign rd_int = req_evt & ~req_wr & (req_addr == `SMC_A_INT);

  always_comb begin
    rd_mux = `SMC_RD_NONE;
    if (req_addr == `SMC_A_INT_SRC) begin
      rd_mux[`SMC_SRC_INT_BIT] = |pend;
    end else if (req_addr == `SMC_A_INT) begin
      rd_mux = {4'h0, int_r};
    end else if (req_addr == `SMC_A_MASK) begin
      rd_mux = {4'h0, mask_r};
    end else if (req_addr == `SMC_A_STATUS) begin
      rd_mux = {1'b0, ce_s, bias_ready_o, io_s, uvlo_r, thermal_shutdown_limit_r, whi_s, wlo_s};
    end else if (req_addr == `SMC_A_RESET) begin
      rd_mux[`SMC_RST_BIT] = soft_reset_bit_r;
    end else if (req_addr == `SMC_A_MEN) begin
      rd_mux = {4'h0, men_r};
    end else if (req_addr == `SMC_A_CFG) begin
      rd_mux = {1'b0, wdt_sel_r, 1'b0, supply_low_fall_level_o};
    end else if (in_grp(req_addr, `SMC_A_VOUT0)) begin
      rd_mux = vout_r[req_addr[1:0]];
    end else if (in_grp(req_addr, `SMC_A_STUP0)) begin
      rd_mux = {3'h0, stup_r[req_addr[1:0]]};
    end else if (in_grp(req_addr, `SMC_A_SHDN0)) begin
      rd_mux = {3'h0, shdn_r[req_addr[1:0]]};
    end
  end

  // Read answer held until the next request
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
      ack_tgl_r <= 1'b0;
    end else if (clk_en_i && req_evt) begin
      rdata_r <= rd_mux;
      ack_tgl_r <= ~ack_tgl_r;
    end
  end

  // System-class configuration
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      supply_low_fall_level_o <= `SMC_UVLO_RST;
      wdt_sel_r <= `SMC_WDT_RST;
      stup_r <= {4{`SMC_STUP_RST}};
      shdn_r <= {4{`SMC_SHDN_RST}};
    end else if (clk_en_i) begin
      if (sys_rst) begin
        supply_low_fall_level_o <= `SMC_UVLO_RST;
        wdt_sel_r <= `SMC_WDT_RST;
        stup_r <= {4{`SMC_STUP_RST}};
        shdn_r <= {4{`SMC_SHDN_RST}};
      end else if (req_evt && req_wr) begin
        if (req_addr == `SMC_A_CFG) begin
          supply_low_fall_level_o <= req_wdata[`SMC_CFG_UVLO_LSB +: 3];
          wdt_sel_r <= req_wdata[`SMC_CFG_WDT_LSB +: 3];
        end
        if (in_grp(req_addr, `SMC_A_STUP0)) begin
          stup_r[req_addr[1:0]] <= req_wdata[4:0];
        end
        if (in_grp(req_addr, `SMC_A_SHDN0)) begin
          shdn_r[req_addr[1:0]] <= req_wdata[4:0];
        end
      end
    end
  end

  // Off-class registers
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      men_r <= 4'h0;
      mask_r <= `SMC_MASK_RST;
      vout_r <= {4{`SMC_VOUT_RST}};
    end else if (clk_en_i) begin
      if (off_rst) begin
        men_r <= 4'h0;
        mask_r <= `SMC_MASK_RST;
        vout_r <= {4{`SMC_VOUT_RST}};
      end else begin
        if (wdt_evt) begin
          vout_r <= {4{`SMC_VOUT_RST}};
        end else if (req_evt && req_wr && in_grp(req_addr, `SMC_A_VOUT0)) begin
          vout_r[req_addr[1:0]] <= req_wdata;
        end
        if (req_evt && req_wr && req_addr == `SMC_A_MEN) begin
          men_r <= req_wdata[3:0];
        end
        if (req_evt && req_wr && req_addr == `SMC_A_MASK) begin
          mask_r <= req_wdata[3:0];
        end
      end
    end
  end
  assign master_voltage_setting_o = vout_r;

  // Soft reset bit, cleared by the reset it causes
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      soft_reset_bit_r <= 1'b0;
    end else if (clk_en_i) begin
      if (req_evt && req_wr && req_addr == `SMC_A_RESET && req_wdata[`SMC_RST_BIT]) begin
        soft_reset_bit_r <= 1'b1;
      end else if (off_rst) begin
        soft_reset_bit_r <= 1'b0;
      end
    end
  end

  // Interrupt capture: edges, unmask capture, set beats clear-on-read
  assign cond = {wdt_fired_r, thermal_shutdown_limit_r, whi_s, wlo_s};
  assign evt = cond & (~cond_d_r | mask_d_r) & ~mask_r;
  assign pend = int_r & ~mask_r;
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      int_r <= 4'h0;
      cond_d_r <= 4'h0;
      mask_d_r <= `SMC_MASK_RST;
      irq_n_o <= 1'b1;
    end else if (clk_en_i) begin
      cond_d_r <= cond;
      mask_d_r <= mask_r;
      if (sys_rst) begin
        int_r <= 4'h0;
      end else begin
        int_r <= (rd_int ? 4'h0 : int_r) | evt;
      end
      irq_n_o <= ~|pend;
    end
  end

  smc_spi_link u_link (
    .arst_n_i(arst_n_i),
    .sclk_i(spi_sclk_i),
    .cs_n_i(spi_cs_n_i),
    .mosi_i(spi_mosi_i),
    .miso_o(spi_miso_o),
    .miso_oe_o(spi_miso_oe_o),
    .req_tgl_o(req_tgl),
    .req_wr_o(req_wr),
    .req_addr_o(req_addr),
    .req_wdata_o(req_wdata),
    .ack_tgl_i(ack_tgl_r),
    .rdata_i(rdata_r)
  );
endmodule // smc_top

// file: tb/smc_host_model.sv
// Host side of the serial register link, 80 ns clock made per frame.
// Assumes mode 0 frames; read data returns in the third byte.
`timescale 1ns/1ps
module smc_host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i,
  input wire logic miso_oe_i
);
  logic last_r = 1'b0;
  logic miso_w;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // Released line shows inverted last bit
  assign miso_w = miso_oe_i ? miso_i : ~last_r;
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    logic [23:0] sh;
    sh = {rd, a, d, 8'h00};
    q = 8'h00;
    #3;
    cs_n_o = 1'b0;
    for (int i = 0; i < (rd ? 24 : 16); i++) begin
      mosi_o = sh[23 - i];
      #40;
      sclk_o = 1'b1;
      if (i >= 16) begin
        q = {q[6:0], miso_w};
        last_r = miso_w;
      end
      #40;
      sclk_o = 1'b0;
    end
    #40;
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #80;
  endtask
endmodule // smc_host_model

// file: tb/smc_top_properties.sv
// Port-level checker for smc_top, bound to every instance.
// Assumes async inputs settle within three cycles of sync delay.
`timescale 1ns/1ps
module smc_top_chk #(
  parameter int BIAS_CYC = 5000
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic por_ok_i,
  input wire logic supply_fall_trip_i,
  input wire logic io_supply_ok_i,
  input wire logic therm_shdn_i,
  input wire logic chip_enable_i,
  input wire logic [3:0] master_input_enable_i,
  input wire logic ref_enable_o,
  input wire logic otp_load_o,
  input wire logic standby_o,
  input wire logic bias_ready_o,
  input wire logic soft_stop_o,
  input wire logic [3:0] master_on_o
);
  localparam int BIAS_LO = BIAS_CYC - 2;
  localparam int BIAS_HI = BIAS_CYC + 2;
  logic [15:0] bcnt_r;
  // Cycles spent in standby waiting for bias
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bcnt_r <= 16'h0000;
    end else if (!standby_o) begin
      bcnt_r <= 16'h0000;
    end else if (!bias_ready_o) begin
      bcnt_r <= bcnt_r + 16'h0001;
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  property p_ce_off; !chip_enable_i [*6] |-> !standby_o && master_on_o == 4'h0; endproperty
  a_ce_off: assert property (p_ce_off) else $error("standby with chip enable low");
  property p_io_off; !io_supply_ok_i [*6] |-> !standby_o && !bias_ready_o; endproperty
  a_io_off: assert property (p_io_off) else $error("running with io supply bad");
  property p_uvlo_off; supply_fall_trip_i [*6] |-> !standby_o && master_on_o == 4'h0; endproperty
  a_uvlo_off: assert property (p_uvlo_off) else $error("running in undervoltage");
  property p_therm; therm_shdn_i [*6] |-> soft_stop_o && master_on_o == 4'h0; endproperty
  a_therm: assert property (p_therm) else $error("no soft stop when hot");
  property p_por_off; !por_ok_i [*6] |-> !ref_enable_o && !standby_o; endproperty
  a_por_off: assert property (p_por_off) else $error("running below power-on level");
  property p_otp; $rose(ref_enable_o) |-> (otp_load_o || $past(otp_load_o)) or ##1 otp_load_o;
  endproperty
  a_otp: assert property (p_otp) else $error("no default load at power-on");
  property p_bias_early; $rose(bias_ready_o) |-> bcnt_r >= BIAS_LO && bcnt_r <= BIAS_HI; endproperty
  a_bias_early: assert property (p_bias_early) else $error("bias settle time wrong");
  property p_bias_wait; standby_o && !bias_ready_o |-> bcnt_r <= BIAS_HI; endproperty
  a_bias_wait: assert property (p_bias_wait) else $error("bias never settles");
  property p_on_bias; master_on_o != 4'h0 |-> $past(bias_ready_o); endproperty
  a_on_bias: assert property (p_on_bias) else $error("master on before bias");
  property p_or; (bias_ready_o && master_input_enable_i == 4'hF) [*5] |-> master_on_o == 4'hF;
  endproperty
  a_or: assert property (p_or) else $error("input enable ignored");
endmodule // smc_top_chk

bind smc_top smc_top_chk #(.BIAS_CYC(BIAS_CYC)) u_chk (
  .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .por_ok_i(por_ok_i),
  .supply_fall_trip_i(supply_fall_trip_i), .io_supply_ok_i(io_supply_ok_i),
  .therm_shdn_i(therm_shdn_i), .chip_enable_i(chip_enable_i),
  .master_input_enable_i(master_input_enable_i), .ref_enable_o(ref_enable_o),
  .otp_load_o(otp_load_o), .standby_o(standby_o), .bias_ready_o(bias_ready_o),
  .soft_stop_o(soft_stop_o), .master_on_o(master_on_o)
);

// file: tb/tb.sv
// Self-checking bench for smc_top: registers, enables, sequencer, interrupts, resets.
// Assumes smc_host_model as link host and the bound checker.
`timescale 1ns/1ps
module tb;
  import smc_pkg::*;
  logic ref_clk_i = 1'b0;
  logic arst_n = 1'b0;
  logic chip_en = 1'b1, por_ok = 1'b1, fall_trip = 1'b0, rise_ok = 1'b1, io_ok = 1'b1;
  logic shdn = 1'b0, cool = 1'b1, warn_lo = 1'b0, warn_hi = 1'b0, en_pin = 1'b0, gef = 1'b0;
  logic wdog_n = 1'b1;
  logic [3:0] men_in = 4'h0;
  logic sclk, cs_n, mosi, miso, miso_oe, ref_en, otp, stby, bias, sstop, irq_n;
  logic [3:0] mon;
  smc_vout_t vout;
  logic [2:0] lvl;
  int fail_count = 0;
  int tests_run = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  smc_host_model u_host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso),
    .miso_oe_i(miso_oe));
  smc_top #(.BIAS_CYC(20), .MS_CYC(10)) DUT (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n),
    .clk_en_i(1'b1), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi),
    .spi_miso_o(miso), .spi_miso_oe_o(miso_oe), .por_ok_i(por_ok),
    .supply_fall_trip_i(fall_trip), .supply_rise_ok_i(rise_ok), .io_supply_ok_i(io_ok),
    .therm_shdn_i(shdn), .therm_cool_i(cool), .therm_warn_lo_i(warn_lo),
    .therm_warn_hi_i(warn_hi), .chip_enable_i(chip_en), .en_pin_i(en_pin),
    .global_enable_function_i(gef), .master_input_enable_i(men_in),
    .watchdog_reset_n_input_i(wdog_n), .ref_enable_o(ref_en), .otp_load_o(otp),
    .standby_o(stby), .bias_ready_o(bias), .soft_stop_o(sstop), .master_on_o(mon),
    .master_voltage_setting_o(vout), .supply_low_fall_level_o(lvl), .irq_n_o(irq_n));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    u_host.xfer(1'b0, a, d, q);
    cyc(1);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] q;
    u_host.xfer(1'b1, a, 8'h00, q);
    chk($sformatf("reg_%h", a), q, e);
    cyc(1);
  endtask
  task automatic seq(input int n, input logic [3:0] e);
    cyc(n);
    chk("master_on", {4'h0, mon}, {4'h0, e});
  endtask
  task automatic fault(input int k, input logic on);
    @(negedge ref_clk_i);
    chip_en = !(on && k == 0);
    io_ok = !(on && k == 1);
    fall_trip = on && k == 2;
    rise_ok = !(on && k == 2);
    shdn = on && k == 3;
    cool = !(on && k == 3);
    por_ok = !(on && k == 4);
  endtask
  initial begin
    #400000;
    fail_count++;
    finish_test();
  end
  initial begin
    cyc(4);
    arst_n = 1'b1;
    cyc(40);
    rd(7'h03, 8'h0F);
    rd(7'h07, 8'h23);
    rd(7'h08, 8'h8C);
    rd(7'h0D, 8'h01);
    rd(7'h10, 8'h00);
    rd(7'h02, 8'h00);
    rd(7'h7F, 8'h00);
    rd(7'h04, 8'h70);
    wr(7'h07, 8'h25);
    cyc(2);
    chk("fall_level", {5'h00, lvl}, 8'h05);
    $display("test registers done");
    men_in = 4'hF;
    seq(8, 4'hF);
    men_in = 4'h0;
    wr(7'h06, 8'h04);
    seq(3, 4'h4);
    $display("test enables done");
    wr(7'h0F, 8'h03);
    wr(7'h11, 8'h02);
    cyc(1);
    en_pin = 1'b1;
    seq(12, 4'h5);
    seq(23, 4'h7);
    seq(45, 4'hF);
    cyc(700);
    en_pin = 1'b0;
    seq(12, 4'h6);
    seq(43, 4'h4);
    cyc(700);
    wr(7'h06, 8'h00);
    gef = 1'b1;
    seq(8, 4'h1);
    gef = 1'b0;
    cyc(10);
    $display("test sequencer done");
    cyc(1);
    warn_lo = 1'b1;
    seq(6, 4'h0);
    chk("irq_n", {7'h00, irq_n}, 8'h01);
    wr(7'h03, 8'h0E);
    cyc(6);
    chk("irq_n", {7'h00, irq_n}, 8'h00);
    rd(7'h01, 8'h01);
    rd(7'h02, 8'h01);
    cyc(3);
    chk("irq_n", {7'h00, irq_n}, 8'h01);
    rd(7'h02, 8'h00);
    warn_lo = 1'b0;
    wr(7'h03, 8'h0C);
    cyc(1);
    warn_hi = 1'b1;
    cyc(6);
    chk("irq_n", {7'h00, irq_n}, 8'h00);
    wr(7'h03, 8'h0F);
    cyc(4);
    chk("irq_n", {7'h00, irq_n}, 8'h01);
    rd(7'h02, 8'h02);
    warn_hi = 1'b0;
    $display("test interrupts done");
    wr(7'h08, 8'h40);
    rd(7'h08, 8'h40);
    cyc(1);
    wdog_n = 1'b0;
    cyc(100);
    wdog_n = 1'b1;
    rd(7'h08, 8'h8C);
    chk("vout", vout[0], 8'h8C);
    wr(7'h06, 8'h03);
    wr(7'h03, 8'h00);
    wr(7'h05, 8'h01);
    rd(7'h05, 8'h00);
    rd(7'h06, 8'h00);
    rd(7'h03, 8'h0F);
    $display("test resets done");
    for (int k = 0; k < 5; k++) begin
      wr(7'h06, 8'h01);
      fault(k, 1'b1);
      cyc(8);
      chk("standby", {7'h00, stby}, 8'h00);
      fault(k, 1'b0);
      cyc(40);
      chk("standby", {7'h00, stby}, 8'h01);
      rd(7'h06, 8'h00);
    end
    rd(7'h07, 8'h23);
    $display("test faults done");
    finish_test();
  end
endmodule // tb
